// >>> dv/qdsu_host.sv
// Serial host model that drives write frames
`timescale 1ns/1ps
module qdsu_host
(
    output logic sclk_o,
    output logic sync_n_o,
    output logic din_o
);
    initial
    begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        din_o = 1'b0;
    end
    // Frame of n bits MSB first, data set while clock high, idle data inverted
    task automatic send(input logic [31:0] w, input int n, input int hp);
        sync_n_o = 1'b0;
        #(hp);
        for (int i = 0; i < n; i++)
        begin
            din_o = (i < 32) ? w[31 - i] : ~din_o;
            #(hp) sclk_o = 1'b0;
            #(hp) sclk_o = 1'b1;
        end
        #(hp) sync_n_o = 1'b1;
        din_o = ~din_o;
        #(4 * hp);
    endtask
endmodule

// >>> dv/qdsu_monitor.sv
// Port checker for the quad serial update control block
`timescale 1ns/1ps
module qdsu_monitor
#(
    parameter DATA_W = 16
)
(
    input wire              clk_i,
    input wire              sys_rst_i,
    input wire              frame_sync_n_i,
    input wire              load_strobe_n_i,
    input wire              async_clear_n_i,
    input wire              pwrup_mid_i,
    input wire [1:0]        clear_code_sel_i,
    input wire              clear_code_we_i,
    input wire              frame_active_o,
    input wire              frame_done_o,
    input wire [DATA_W-1:0] out_a_o,
    input wire [DATA_W-1:0] out_b_o,
    input wire [DATA_W-1:0] out_c_o,
    input wire [DATA_W-1:0] out_d_o
);
    logic [1:0]          code_reg;
    logic [1:0]          dones_reg;
    wire  [DATA_W-1:0]   cval;
    wire  [4*DATA_W-1:0] outs = {out_a_o, out_b_o, out_c_o, out_d_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
            code_reg <= 2'h0;
        else if (clear_code_we_i)
            code_reg <= clear_code_sel_i;
        if (sys_rst_i || !frame_active_o)
            dones_reg <= 2'h0;
        else if (frame_done_o && dones_reg != 2'h3)
            dones_reg <= dones_reg + 2'h1;
    end
    assign cval = (code_reg == 2'h1) ? 16'h8000 : (code_reg == 2'h2) ? 16'hFFFF : 16'h0000;
    // ********************
    // Assertions
    // ********************
    AST_ACT_ON_SYNC: assert property ($fell(frame_sync_n_i) |-> ##[1:5] frame_active_o)
        else $error("frame not active after sync fall");
    AST_DONE_IN_FRAME: assert property (frame_done_o |-> frame_active_o)
        else $error("frame done outside a frame");
    AST_ONE_DONE: assert property (frame_done_o |-> dones_reg == 2'h0)
        else $error("second frame done in one frame");
    AST_ABORT: assert property ($rose(frame_sync_n_i) |-> ##[1:5] !frame_active_o)
        else $error("frame still active after sync rise");
    AST_PWRUP: assert property ($fell(sys_rst_i) |-> ##[1:4]
        (out_a_o == (pwrup_mid_i ? 16'h8000 : 16'h0000) && out_d_o == out_a_o))
        else $error("power-up value wrong");
    AST_CLR_LOAD: assert property ($fell(async_clear_n_i) |-> ##[2:7]
        (out_a_o == cval && out_b_o == cval && out_c_o == cval && out_d_o == cval))
        else $error("clear value not loaded");
    AST_CLR_HOLD: assert property ((!async_clear_n_i)[*8] |-> $stable(outs))
        else $error("outputs moved while clear low");
    AST_LD_HOLD: assert property ((load_strobe_n_i && async_clear_n_i)[*8] |-> $stable(outs))
        else $error("outputs moved without load strobe");
    COV_FRAME: cover property (frame_done_o);
    COV_ABORT: cover property ($rose(frame_sync_n_i));
    COV_CLEAR: cover property ($fell(async_clear_n_i));
endmodule

// >>> dv/tb_top.sv
// Testbench with a reference model for the quad serial update control
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 0;
    logic        sys_rst_i = 1;
    logic        ldn = 1;
    logic        clrn = 1;
    logic        pm = 1;
    logic        we = 0;
    logic [1:0]  sel = 0;
    logic        ce = 1;
    logic [31:0] sreg = 0;
    wire         sclk, syncn, din, so;
    wire  [15:0] o [4];
    int          fails = 0, num_checks = 0, cv = 0;
    int          inq [4], outq [4];
    bit          nw [4];
    qdsu_host u_qdsu_host (.sclk_o(sclk), .sync_n_o(syncn), .din_o(din));
    qdsu_top u_qdsu_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .sclk_i(sclk),
        .frame_sync_n_i(syncn), .din_i(din), .load_strobe_n_i(ldn), .async_clear_n_i(clrn),
        .pwrup_mid_i(pm), .clear_code_sel_i(sel), .clear_code_we_i(we), .serial_out_o(so),
        .frame_active_o(), .frame_done_o(), .out_a_o(o[0]), .out_b_o(o[1]),
        .out_c_o(o[2]), .out_d_o(o[3]));
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    task automatic chk(input string nm, input int exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp[15:0])
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp[15:0], got);
        end
    endtask
    task automatic chk_outs;
        for (int i = 0; i < 4; i++)
            chk($sformatf("out%0d", i), outq[i], o[i]);
    endtask
    // ********************
    // Reference model
    // ********************
    task automatic set_all(input int v);
        for (int i = 0; i < 4; i++)
        begin
            inq[i] = v;
            outq[i] = v;
            nw[i] = 0;
        end
    endtask
    task automatic mload;
        for (int i = 0; i < 4; i++)
            if (nw[i] && clrn)
            begin
                outq[i] = inq[i];
                nw[i] = 0;
            end
    endtask
    task automatic write(input logic [31:0] w, input int n);
        int so_exp;
        so_exp = sreg[31 - ((n >= 32) ? 31 : n)];
        u_qdsu_host.send(w, n, 200);
        chk("serial_out", so_exp, {15'h0000, so});
        sreg = (n >= 32) ? w : ((sreg << n) | (w >> (32 - n)));
        if (n >= 32)
        begin
            inq[w[21:20]] = w[19:4];
            nw[w[21:20]] = 1;
        end
        if (!ldn)
            mload();
        step(2);
    endtask
    task automatic pulse;
        ldn = 0;
        step(4);
        ldn = 1;
        step(8);
        mload();
    endtask
    task automatic clear(input int k);
        if (k >= 0)
        begin
            sel = k[1:0];
            we = 1;
            step(1);
            we = 0;
            cv = (k == 1) ? 32'h8000 : (k == 2) ? 32'hFFFF : 0;
        end
        clrn = 0;
        step(10);
        set_all(cv);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #1ms;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(32'h5E6CD3AA));
        for (int r = 0; r < 2; r++)
        begin
            pm = (r == 0);
            sys_rst_i = 1;
            step(5);
            sys_rst_i = 0;
            step(10);
            cv = 0;
            set_all(pm ? 32'h8000 : 0);
            chk_outs();
        end
        for (int i = 0; i < 4; i++)
            write(($urandom & 32'hFFCFFFFF) | (i << 20), 32);
        chk_outs();
        ce = 0;
        ldn = 0;
        step(8);
        ldn = 1;
        step(2);
        ce = 1;
        step(6);
        chk_outs();
        pulse();
        chk_outs();
        write($urandom, 20);
        pulse();
        chk_outs();
        clear(-1);
        chk_outs();
        write($urandom, 32);
        pulse();
        chk_outs();
        clrn = 1;
        step(2);
        pulse();
        chk_outs();
        for (int k = 3; k >= 0; k--)
        begin
            clear(k);
            chk_outs();
            clrn = 1;
            step(4);
        end
        ldn = 0;
        for (int j = 32; j < 37; j++)
        begin
            write($urandom, j);
            chk_outs();
        end
        tally_and_finish();
    end
endmodule
bind qdsu_top qdsu_monitor #(.DATA_W(DATA_W)) u_qdsu_monitor (.*);

// >>> shared/qdsu_defs.vh
// Constants for the quad converter serial update control block
`ifndef QDSU_DEFS_VH
`define QDSU_DEFS_VH

// ****************************************************************
// Frame format
// ****************************************************************
`define QDSU_FRAME_BITS      32
`define QDSU_CNT_W          6
`define QDSU_CNT_ZERO       6'h00
`define QDSU_CNT_FULL       6'h20
`define QDSU_NUM_CH         4
`define QDSU_DATA_W         16
`define QDSU_CH_W           2

// ****************************************************************
// Field positions in the 32-bit word
// ****************************************************************
`define QDSU_DATA_LSB       4
`define QDSU_DATA_MSB       19
`define QDSU_ADDR_LSB       20
`define QDSU_ADDR_MSB       21

// ****************************************************************
// Clear code selections and scale values
// ****************************************************************
`define QDSU_CLR_ZERO       2'h0
`define QDSU_CLR_MID        2'h1
`define QDSU_CLR_FULL       2'h2
`define QDSU_VAL_ZERO       16'h0000
`define QDSU_VAL_MID        16'h8000
`define QDSU_VAL_FULL       16'hFFFF

`endif

// >>> src/qdsu_sync2.v
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps

module qdsu_sync2
#(
    parameter RESET_VAL = 1'b0
)
(
    input  wire clk_i,
    input  wire sys_rst_i,
    input  wire ce_i,
    input  wire d_i,
    output wire q_o
);

    reg meta_reg;
    reg sync_reg;

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end
        else if (ce_i)
        begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule

// >>> src/qdsu_top.v
// Serial write, load strobe and clear control of a quad converter
`timescale 1ns/1ps
`include "qdsu_defs.vh"

// Behaviour
// - Falling frame sync enables the shift register and starts a frame
// - Capture one data bit on each of the next 32 falling serial clock edges
// - Frame sync rising before bit 32 aborts and discards the write
// - Serial input path is a 32-bit shift register, one bit per fall
// - Load strobe low copies input registers with new data into outputs
// - One load strobe updates all four outputs together
// - Strobe pulsed or held low; held low updates on each completed write
// - Clear input acts on its falling edge, independent of serial clock
// - Load strobe is ignored while clear is low
// - Clear loads input and output registers with the clear code
// - Clear code resets to zero scale
// - Power-up select low gives zero scale, high gives midscale
// - Serial out shifts on rising serial clock edges between frame start and bit 32
module qdsu_top
#(
    parameter DATA_W = `QDSU_DATA_W
)
(
    input  wire                clk_i,
    input  wire                sys_rst_i,
    input  wire                ce_i,
    input  wire                sclk_i,
    input  wire                frame_sync_n_i,
    input  wire                din_i,
    input  wire                load_strobe_n_i,
    input  wire                async_clear_n_i,
    input  wire                pwrup_mid_i,
    input  wire [1:0]          clear_code_sel_i,
    input  wire                clear_code_we_i,
    output reg                 serial_out_o,
    output reg                 frame_active_o,
    output reg                 frame_done_o,
    output reg  [DATA_W-1:0]   out_a_o,
    output reg  [DATA_W-1:0]   out_b_o,
    output reg  [DATA_W-1:0]   out_c_o,
    output reg  [DATA_W-1:0]   out_d_o
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire sclk_s;
    wire fs_n_s;
    wire din_s;
    wire ld_n_s;
    wire clr_n_s;
    wire pwr_s;

    qdsu_sync2 #(.RESET_VAL(1'b1)) u_sync_sclk
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       (sclk_i),
        .q_o       (sclk_s)
    );

    qdsu_sync2 #(.RESET_VAL(1'b1)) u_sync_fs
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       (frame_sync_n_i),
        .q_o       (fs_n_s)
    );

    qdsu_sync2 #(.RESET_VAL(1'b0)) u_sync_din
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       (din_i),
        .q_o       (din_s)
    );

    qdsu_sync2 #(.RESET_VAL(1'b1)) u_sync_ld
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       (load_strobe_n_i),
        .q_o       (ld_n_s)
    );

    qdsu_sync2 #(.RESET_VAL(1'b1)) u_sync_clr
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       (async_clear_n_i),
        .q_o       (clr_n_s)
    );

    // Not reset, so the settled pin level is ready at release
    qdsu_sync2 #(.RESET_VAL(1'b0)) u_sync_pwr
    (
        .clk_i     (clk_i),
        .sys_rst_i (1'b0),
        .ce_i      (ce_i),
        .d_i       (pwrup_mid_i),
        .q_o       (pwr_s)
    );

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    reg sclk_d_reg;
    reg fs_n_d_reg;
    reg clr_n_d_reg;
    reg init_done_reg;

    wire sclk_fall = sclk_d_reg & ~sclk_s;
    wire sclk_rise = ~sclk_d_reg & sclk_s;
    wire fs_fall   = fs_n_d_reg & ~fs_n_s;
    wire fs_rise   = ~fs_n_d_reg & fs_n_s;
    wire clr_fall  = clr_n_d_reg & ~clr_n_s;

    // ****************************************************************
    // Frame state and shift register
    // ****************************************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam ST_HOLD = 2'b10;

    reg [1:0]                    state_reg;
    reg [`QDSU_CNT_W-1:0]        cnt_reg;
    reg [`QDSU_FRAME_BITS-1:0]   shift_reg;
    reg                          exec_reg;

    // ****************************************************************
    // Channel registers
    // ****************************************************************
    reg [DATA_W-1:0]             in_reg   [0:`QDSU_NUM_CH-1];
    reg [DATA_W-1:0]             out_reg  [0:`QDSU_NUM_CH-1];
    reg [`QDSU_NUM_CH-1:0]       new_reg;
    reg [1:0]                    clr_code_reg;
    reg [DATA_W-1:0]             clr_val;

    wire [`QDSU_CH_W-1:0] wr_ch  = shift_reg[`QDSU_ADDR_MSB:`QDSU_ADDR_LSB];
    wire [DATA_W-1:0]     wr_dat = shift_reg[`QDSU_DATA_LSB+DATA_W-1:`QDSU_DATA_LSB];
    wire                  do_load = ~ld_n_s & clr_n_s;

    always @*
    begin
        case (clr_code_reg)
            `QDSU_CLR_MID:  clr_val = `QDSU_VAL_MID;
            `QDSU_CLR_FULL: clr_val = `QDSU_VAL_FULL;
            default:        clr_val = `QDSU_VAL_ZERO;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sclk_d_reg     <= 1'b1;
            fs_n_d_reg     <= 1'b1;
            clr_n_d_reg    <= 1'b1;
            state_reg      <= ST_IDLE;
            cnt_reg        <= `QDSU_CNT_ZERO;
            shift_reg      <= {`QDSU_FRAME_BITS{1'b0}};
            exec_reg       <= 1'b0;
            frame_active_o <= 1'b0;
            frame_done_o   <= 1'b0;
            serial_out_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            sclk_d_reg   <= sclk_s;
            fs_n_d_reg   <= fs_n_s;
            clr_n_d_reg  <= clr_n_s;
            exec_reg     <= 1'b0;
            frame_done_o <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (fs_fall)
                    begin
                        state_reg      <= ST_SHIFT;
                        cnt_reg        <= `QDSU_CNT_ZERO;
                        frame_active_o <= 1'b1;
                    end
                end
                ST_SHIFT:
                begin
                    if (fs_rise)
                    begin
                        state_reg      <= ST_IDLE;
                        frame_active_o <= 1'b0;
                    end
                    else if (sclk_fall)
                    begin
                        shift_reg <= {shift_reg[`QDSU_FRAME_BITS-2:0], din_s};
                        cnt_reg   <= cnt_reg + 6'h01;
                        if (cnt_reg == `QDSU_CNT_FULL - 6'h01)
                        begin
                            state_reg    <= ST_HOLD;
                            exec_reg     <= 1'b1;
                            frame_done_o <= 1'b1;
                        end
                    end
                    else if (sclk_rise)
                    begin
                        serial_out_o <= shift_reg[`QDSU_FRAME_BITS-1];
                    end
                end
                ST_HOLD:
                begin
                    if (fs_rise)
                    begin
                        state_reg      <= ST_IDLE;
                        frame_active_o <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Clear code, input and output registers
    // ****************************************************************
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            clr_code_reg  <= `QDSU_CLR_ZERO;
            init_done_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            init_done_reg <= 1'b1;
            if (clear_code_we_i)
                clr_code_reg <= clear_code_sel_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `QDSU_NUM_CH; g = g + 1)
        begin : g_ch
            always @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    in_reg[g]  <= {DATA_W{1'b0}};
                    out_reg[g] <= {DATA_W{1'b0}};
                    new_reg[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    if (!init_done_reg)
                    begin
                        in_reg[g]  <= pwr_s ? `QDSU_VAL_MID : `QDSU_VAL_ZERO;
                        out_reg[g] <= pwr_s ? `QDSU_VAL_MID : `QDSU_VAL_ZERO;
                    end
                    else if (clr_fall)
                    begin
                        in_reg[g]  <= clr_val;
                        out_reg[g] <= clr_val;
                        new_reg[g] <= 1'b0;
                    end
                    else if (exec_reg && wr_ch == g)
                    begin
                        in_reg[g]  <= wr_dat;
                        new_reg[g] <= 1'b1;
                        if (do_load)
                        begin
                            out_reg[g] <= wr_dat;
                            new_reg[g] <= 1'b0;
                        end
                    end
                    else if (do_load && new_reg[g])
                    begin
                        out_reg[g] <= in_reg[g];
                        new_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            out_a_o <= {DATA_W{1'b0}};
            out_b_o <= {DATA_W{1'b0}};
            out_c_o <= {DATA_W{1'b0}};
            out_d_o <= {DATA_W{1'b0}};
        end
        else if (ce_i)
        begin
            out_a_o <= out_reg[0];
            out_b_o <= out_reg[1];
            out_c_o <= out_reg[2];
            out_d_o <= out_reg[3];
        end
    end

endmodule
